/* dv/cms_mode_segment_assertions.sv */
// concurrent checks on the mode and segment map ports
`timescale 1ns/1ps
module cms_mode_segment_chk #(
  parameter bit HAS_XLATE = 1'b1,
  parameter int ENTRIES = 64,
  parameter logic [31:0] REV_ID = cms_pkg::CMS_REV_ID_DEFAULT
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire cms_pkg::cms_access_s access, // access
  input wire cms_pkg::cms_xlate_s xlate, // result
  input wire cms_pkg::cms_except_s excIn, // exception
  input wire cms_pkg::cms_op_e opIn, // operation
  input wire logic [1:0] copNum, // coprocessor
  input wire logic moveTo, // move to
  input wire logic moveFrom, // move from
  input wire logic [4:0] regSel, // register
  input wire logic [31:0] wrData, // data
  input wire logic [31:0] rdData_q, // read data
  input wire logic kernelMode_q, // mode
  input wire logic [3:0] copSel_q, // select
  input wire logic addrErr_q, // error
  input wire logic [5:0] randomIdx_q // random
);
  import cms_pkg::*;
  logic [28:0] lowOff;
  assign lowOff = access.vaddr[28:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_user_fault: assert property (
    access.valid && !kernelMode_q && access.vaddr[31]
    |=> xlate.fault && addrErr_q && xlate.seg == CMS_SEG_FAULT ##1 kernelMode_q)
    else $error("user access to upper half did not fault");
  a_user_half: assert property (
    access.valid && !access.vaddr[31] |=> xlate.valid && !addrErr_q)
    else $error("lower half access flagged");
  a_kcached_map: assert property (
    access.valid && kernelMode_q && access.vaddr[31:29] == 3'h4
    |=> xlate.cached && !xlate.mapped && xlate.paddr == {3'h0, $past(lowOff)})
    else $error("cached kernel segment mapped wrongly");
  a_kuncached_map: assert property (
    access.valid && kernelMode_q && access.vaddr[31:29] == 3'h5
    |=> !xlate.cached && !xlate.mapped && xlate.paddr == {3'h0, $past(lowOff)})
    else $error("uncached kernel segment mapped wrongly");
  a_kmapped_seg: assert property (
    access.valid && kernelMode_q && access.vaddr[31:30] == 2'b11
    |=> xlate.seg == CMS_SEG_KMAPPED && xlate.mapped == HAS_XLATE)
    else $error("upper kernel segment not mapped");
  a_exc_kernel: assert property (
    excIn.valid |=> kernelMode_q)
    else $error("exception left user mode");
  a_kernel_hold: assert property (
    kernelMode_q && opIn != CMS_OP_RESTORE |=> kernelMode_q)
    else $error("kernel mode dropped without restore");
  a_revid_read: assert property (
    moveFrom && copNum == 2'h0 && regSel == CMS_REG_REV_ID |=> rdData_q == REV_ID)
    else $error("revision id read wrong");
  a_cop_select: assert property (
    (moveTo || moveFrom) && !excIn.valid |=> copSel_q == 4'h1 << $past(copNum))
    else $error("coprocessor select wrong");
  a_random_wrap: assert property (
    randomIdx_q == 6'h08 |=> randomIdx_q == 6'h3F)
    else $error("random pointer did not wrap");
endmodule

bind cms_mode_segment cms_mode_segment_chk #(.HAS_XLATE(HAS_XLATE), .ENTRIES(ENTRIES), .REV_ID(REV_ID)) u_chk (
  .clk(clk), .rst_n(rst_n), .access(access), .xlate(xlate), .excIn(excIn), .opIn(opIn),
  .copNum(copNum), .moveTo(moveTo), .moveFrom(moveFrom), .regSel(regSel), .wrData(wrData),
  .rdData_q(rdData_q), .kernelMode_q(kernelMode_q), .copSel_q(copSel_q), .addrErr_q(addrErr_q),
  .randomIdx_q(randomIdx_q)
);

/* dv/cms_pipe_model.sv */
// pipeline-side model that raises exceptions and offers a restart pc
`timescale 1ns/1ps
module cms_pipe_model (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic raise, // request
  input wire logic [4:0] code, // cause code
  output cms_pkg::cms_except_s excIn // to block
);
  import cms_pkg::*;
  logic [31:0] pc_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= 32'h0000_1000;
    end else begin
      pc_q <= pc_q + 32'h0000_0004;
    end
  end
  // pc offered every cycle, since internal address errors take it without a pulse
  always_comb begin
    excIn = '0;
    excIn.valid = raise;
    excIn.code = code;
    excIn.pc = pc_q;
  end
endmodule

/* dv/tb_cms_mode_segment.sv */
// self-checking bench for the mode and segment map
`timescale 1ns/1ps
module tb_cms_mode_segment;
  import cms_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cms_access_s access = '0;
  cms_xlate_s xlate;
  cms_except_s excIn;
  cms_op_e opIn = CMS_OP_NONE;
  logic [1:0] copNum = 2'h0;
  logic moveTo = 1'b0;
  logic moveFrom = 1'b0;
  logic [4:0] regSel = 5'h00;
  logic [31:0] wrData = 32'h0000_0000;
  logic [31:0] rdData_q;
  logic kernelMode_q;
  logic [3:0] copSel_q;
  logic addrErr_q;
  logic [5:0] randomIdx_q;
  logic raise = 1'b0;
  logic [4:0] code = 5'h00;
  int errTotal = 0;
  int checks = 0;
  integer seed = 32'h12b0;
  logic [31:0] rd;
  logic [31:0] v;
  always #20 clk = ~clk;
  cms_mode_segment u_cms_mode_segment (.clk(clk), .rst_n(rst_n), .access(access), .xlate(xlate),
    .excIn(excIn), .opIn(opIn), .copNum(copNum), .moveTo(moveTo), .moveFrom(moveFrom), .regSel(regSel),
    .wrData(wrData), .rdData_q(rdData_q), .kernelMode_q(kernelMode_q), .copSel_q(copSel_q),
    .addrErr_q(addrErr_q), .randomIdx_q(randomIdx_q));
  cms_pipe_model u_cms_pipe_model (.clk(clk), .rst_n(rst_n), .raise(raise), .code(code), .excIn(excIn));
  task automatic results();
    if (errTotal == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic mvw(input logic [4:0] sel, input logic [31:0] d);
    @(posedge clk);
    moveTo <= 1'b1;
    regSel <= sel;
    wrData <= d;
    @(posedge clk);
    moveTo <= 1'b0;
  endtask
  task automatic mvr(input logic [4:0] sel);
    @(posedge clk);
    moveFrom <= 1'b1;
    regSel <= sel;
    @(posedge clk);
    moveFrom <= 1'b0;
    #1;
    rd = rdData_q;
  endtask
  task automatic acc(input logic [31:0] a);
    @(posedge clk);
    access <= '{valid: 1'b1, store: 1'b0, vaddr: a};
    @(posedge clk);
    access.valid <= 1'b0;
    #1;
  endtask
  task automatic op(input cms_op_e o);
    @(posedge clk);
    opIn <= o;
    @(posedge clk);
    opIn <= CMS_OP_NONE;
    #1;
  endtask
  function automatic cms_seg_e expSeg(input logic [31:0] a);
    case (a[31:29])
      3'h4: expSeg = CMS_SEG_KCACHED;
      3'h5: expSeg = CMS_SEG_KUNCACHED;
      default: expSeg = CMS_SEG_KMAPPED;
    endcase
  endfunction
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // the internal copy still holds reset here, so these are the reset values
    repeat (2) @(posedge clk);
    #1;
    chk("mode after reset", kernelMode_q, 1'b0);
    chk("random after reset", randomIdx_q, CMS_RANDOM_RST);
    acc(32'h8000_0000);
    chk("fault flags", {xlate.fault, addrErr_q}, 2'b11);
    chk("fault seg", xlate.seg, CMS_SEG_FAULT);
    @(posedge clk);
    #1;
    chk("kernel entry", kernelMode_q, 1'b1);
    mvr(CMS_REG_BAD_VADDR);
    chk("bad address", rd, 32'h8000_0000);
    mvr(CMS_REG_CAUSE);
    chk("cause code", rd[6:2], CMS_CAUSE_ADDR_LOAD);
    mvw(CMS_REG_REV_ID, 32'hFFFF_FFFF);
    mvr(CMS_REG_REV_ID);
    chk("revision", rd, CMS_REV_ID_DEFAULT);
    copNum <= 2'h1;
    mvw(CMS_REG_INDEX, 32'h0000_3F00);
    copNum <= 2'h0;
    #1;
    chk("coproc select", copSel_q, 4'h2);
    v = $random(seed);
    mvw(CMS_REG_CONTEXT, v);
    mvr(CMS_REG_CONTEXT);
    chk("context base", rd & 32'hFFE0_0000, v & 32'hFFE0_0000);
    mvw(CMS_REG_ENTRY_HI, 32'hC000_1000);
    mvw(CMS_REG_ENTRY_LO, 32'h0012_3200);
    mvw(CMS_REG_INDEX, 32'h0000_0500);
    op(CMS_OP_WRITE_IDX);
    mvw(CMS_REG_ENTRY_HI, 32'h0040_0000);
    mvw(CMS_REG_ENTRY_LO, 32'h0045_6A00);
    op(CMS_OP_WRITE_RND);
    mvw(CMS_REG_ENTRY_HI, 32'hC000_1000);
    op(CMS_OP_PROBE);
    repeat (2) @(posedge clk);
    mvr(CMS_REG_INDEX);
    chk("probe index", rd, 32'h0000_0500);
    mvw(CMS_REG_ENTRY_HI, 32'h0000_0000);
    op(CMS_OP_READ_IDX);
    repeat (2) @(posedge clk);
    mvr(CMS_REG_ENTRY_HI);
    chk("read back high", rd, 32'hC000_1000);
    acc(32'hC000_1ABC);
    chk("mapped kernel", {xlate.mapped, xlate.cached, xlate.seg}, {2'b11, CMS_SEG_KMAPPED});
    chk("mapped paddr", xlate.paddr, 32'h0012_3ABC);
    // corners at the boundary between the two unmapped segments, then random offsets
    for (int i = 0; i < 40; i++) begin
      v = (i == 0) ? 32'h9FFF_FFFF : (i == 1) ? 32'hA000_0000 : {2'b10, 30'($random(seed))};
      acc(v);
      chk("unmapped seg", xlate.seg, expSeg(v));
      chk("unmapped cache", {xlate.mapped, xlate.cached}, {1'b0, v[31:29] == 3'h4});
      chk("unmapped paddr", xlate.paddr, v & 32'h1FFF_FFFF);
    end
    chk("still kernel", kernelMode_q, 1'b1);
    for (int m = 0; m < 2; m++) begin
      acc(32'h0040_0010);
      chk("user seg map", {xlate.seg, xlate.mapped, xlate.cached}, {CMS_SEG_USER, 2'b10});
      chk("user seg paddr", xlate.paddr, 32'h0045_6010);
      if (m == 0) begin
        op(CMS_OP_RESTORE);
        chk("restored to user", kernelMode_q, 1'b0);
      end
    end
    @(posedge clk);
    raise <= 1'b1;
    code <= 5'h08;
    @(posedge clk);
    raise <= 1'b0;
    #1;
    chk("exception mode", kernelMode_q, 1'b1);
    mvr(CMS_REG_CAUSE);
    chk("cause from pipe", rd[6:2], 5'h08);
    op(CMS_OP_RESTORE);
    chk("restore mode", kernelMode_q, 1'b0);
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    results();
  end
endmodule

/* rtl/cms_entry_mem.sv */
`timescale 1ns/1ps
// translation buffer entry store with registered read data
module cms_entry_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk, // core clock
  input wire logic wrEn, // write strobe
  input wire logic [AW-1:0] wrAddr, // write index
  input wire cms_pkg::cms_entry_s wrData, // entry written
  input wire logic [AW-1:0] rdAddr, // read index
  output cms_pkg::cms_entry_s rdData // entry read, one cycle later
);
  import cms_pkg::*;
  cms_entry_s mem [DEPTH];
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

/* rtl/cms_mode_segment.sv */
`timescale 1ns/1ps
// privilege mode, segment map and system control coprocessor registers
module cms_mode_segment #(
  parameter bit HAS_XLATE = 1'b1,
  parameter int ENTRIES = 64,
  parameter logic [31:0] REV_ID = cms_pkg::CMS_REV_ID_DEFAULT // arbitrary value
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire cms_pkg::cms_access_s access, // address to classify
  output cms_pkg::cms_xlate_s xlate, // registered translation result
  input wire cms_pkg::cms_except_s excIn, // exception detected by pipeline
  input wire cms_pkg::cms_op_e opIn, // coprocessor 0 operation
  input wire logic [1:0] copNum, // coprocessor number of a move
  input wire logic moveTo, // move to system coprocessor
  input wire logic moveFrom, // move from system coprocessor
  input wire logic [4:0] regSel, // register number of a move
  input wire logic [31:0] wrData, // move data
  output logic [31:0] rdData_q, // move read data
  output logic kernelMode_q, // high in kernel mode
  output logic [3:0] copSel_q, // one-hot coprocessor selected by last move
  output logic addrErr_q, // one-cycle address error pulse
  output logic [5:0] randomIdx_q // current random pointer
);
  import cms_pkg::*;

  logic rstMeta, rstSync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // status keeps a three-deep mode/enable stack in bits 5:0
  logic [5:0] status_q, status_d;
  logic [31:0] cause_q, cause_d, epc_q, epc_d, faulting_virtual_address_q, faulting_virtual_address_d;
  logic [31:0] ctx_q, ctx_d, entryHi_q, entryHi_d, entryLo_q, entryLo_d;
  logic [31:0] index_q, index_d;
  logic [5:0] random_d;
  logic [31:0] rd_d;
  logic [3:0] copSel_d;
  logic rdPend_q, rdPend_d, probePend_q, probePend_d;
  cms_xlate_s xlate_d;
  logic addrErr_d;
  logic selfMove;

  // entry store and probe match
  cms_entry_s memRd, memWr;
  logic memWe;
  logic [5:0] memWa;
  cms_entry_s tagArr [ENTRIES];
  logic probeHit, lookHit;
  logic [5:0] probeIdx, lookIdx;

  function automatic logic matchEntry(input cms_entry_s e, input logic [19:0] vpn, input logic [5:0] pid);
    matchEntry = e.lo[CMS_LO_VALID_BIT] && e.hi[31:CMS_HI_VPN_LSB] == vpn &&
                 e.hi[CMS_HI_VPN_LSB-1:CMS_HI_PID_LSB] == pid;
  endfunction

  always_comb begin
    probeHit = 1'b0;
    probeIdx = 6'h00;
    lookHit = 1'b0;
    lookIdx = 6'h00;
    for (int i = 0; i < ENTRIES; i++) begin
      if (!probeHit && matchEntry(tagArr[i], entryHi_q[31:CMS_HI_VPN_LSB],
                                  entryHi_q[CMS_HI_VPN_LSB-1:CMS_HI_PID_LSB])) begin
        probeHit = 1'b1;
        probeIdx = 6'(i);
      end
      // lookups match the address page number with the process id held in entry high
      if (!lookHit && matchEntry(tagArr[i], access.vaddr[31:CMS_HI_VPN_LSB],
                                 entryHi_q[CMS_HI_VPN_LSB-1:CMS_HI_PID_LSB])) begin
        lookHit = 1'b1;
        lookIdx = 6'(i);
      end
    end
  end

  cms_entry_mem #(.DEPTH(ENTRIES), .AW(6)) uMem (
    .clk(clk),
    .wrEn(memWe),
    .wrAddr(memWa),
    .wrData(memWr),
    .rdAddr(index_q[CMS_IDX_LSB +: 6]),
    .rdData(memRd)
  );

  // shadow of tags for the associative search; a memory cannot be searched in parallel
  always_ff @(posedge clk) begin
    if (memWe) begin
      tagArr[memWa] <= memWr;
    end
  end

  always_comb begin
    memWr = '{hi: entryHi_q, lo: entryLo_q};
    memWe = HAS_XLATE && (opIn == CMS_OP_WRITE_IDX || opIn == CMS_OP_WRITE_RND);
    memWa = (opIn == CMS_OP_WRITE_RND) ? randomIdx_q : index_q[CMS_IDX_LSB +: 6];
  end

  // segment decode
  always_comb begin
    logic [2:0] top;
    logic [31:0] pa;
    top = access.vaddr[31:29];
    pa = access.vaddr;
    xlate_d = '{valid: access.valid, fault: 1'b0, mapped: 1'b0, cached: 1'b1, paddr: 32'h0000_0000,
                seg: CMS_SEG_USER};
    addrErr_d = 1'b0;
    if (!kernelMode_q && access.vaddr[31]) begin
      xlate_d.seg = CMS_SEG_FAULT;
      xlate_d.fault = 1'b1;
      // a faulted access carries its virtual address so the bad address register can take it
      xlate_d.paddr = access.vaddr;
      addrErr_d = access.valid;
    end else if (!access.vaddr[31] || top >= 3'h6) begin
      // user segment treated alike in both modes
      xlate_d.seg = access.vaddr[31] ? CMS_SEG_KMAPPED : CMS_SEG_USER;
      if (HAS_XLATE) begin
        xlate_d.mapped = 1'b1;
        xlate_d.fault = !lookHit;
        xlate_d.cached = !tagArr[lookIdx].lo[CMS_LO_NC_BIT];
        pa = {tagArr[lookIdx].lo[31:CMS_LO_PFN_LSB], access.vaddr[CMS_LO_PFN_LSB-1:0]};
      end else begin
        // fixed mapping offsets the user segment into physical space; upper kernel addresses pass unchanged
        pa = access.vaddr[31] ? access.vaddr : {access.vaddr[31:30] + 2'b01, access.vaddr[29:0]};
      end
      xlate_d.paddr = pa;
    end else if (top == CMS_SEG_KCACHED_TOP) begin
      xlate_d.seg = CMS_SEG_KCACHED;
      xlate_d.paddr = {3'b000, access.vaddr[28:0]};
    end else begin
      xlate_d.seg = CMS_SEG_KUNCACHED;
      xlate_d.cached = 1'b0;
      xlate_d.paddr = {3'b000, access.vaddr[28:0]};
    end
  end

  // coprocessor 0 registers
  always_comb begin
    status_d = status_q;
    cause_d = cause_q;
    epc_d = epc_q;
    faulting_virtual_address_d = faulting_virtual_address_q;
    ctx_d = ctx_q;
    entryHi_d = entryHi_q;
    entryLo_d = entryLo_q;
    index_d = index_q;
    copSel_d = copSel_q;
    rdPend_d = 1'b0;
    probePend_d = 1'b0;
    rd_d = rdData_q;
    selfMove = (moveTo || moveFrom) && copNum == 2'd0;
    if (moveTo || moveFrom) begin
      copSel_d = 4'(1 << copNum);
    end
    // random counts down from top to the wired low bound, then wraps back to top
    random_d = (randomIdx_q <= CMS_RANDOM_LOW) ? CMS_RANDOM_RST : randomIdx_q - 6'd1;
    if (selfMove && moveTo) begin
      unique case (regSel)
        CMS_REG_INDEX: index_d[CMS_IDX_LSB +: 6] = wrData[CMS_IDX_LSB +: 6];
        CMS_REG_ENTRY_LO: entryLo_d = wrData;
        CMS_REG_ENTRY_HI: entryHi_d = wrData;
        CMS_REG_CONTEXT: ctx_d[31:CMS_CTX_BASE_LSB] = wrData[31:CMS_CTX_BASE_LSB];
        CMS_REG_STATUS: status_d = wrData[5:0];
        CMS_REG_EPC: epc_d = wrData;
        default: ; // revision id and others ignore writes
      endcase
    end
    if (selfMove && moveFrom) begin
      unique case (regSel)
        CMS_REG_INDEX: rd_d = index_q;
        CMS_REG_RANDOM: rd_d = {18'h0, randomIdx_q, 8'h00};
        CMS_REG_ENTRY_LO: rd_d = entryLo_q;
        CMS_REG_ENTRY_HI: rd_d = entryHi_q;
        CMS_REG_CONTEXT: rd_d = ctx_q;
        CMS_REG_BAD_VADDR: rd_d = faulting_virtual_address_q;
        CMS_REG_STATUS: rd_d = {26'h0, status_q};
        CMS_REG_CAUSE: rd_d = cause_q;
        CMS_REG_EPC: rd_d = epc_q;
        CMS_REG_REV_ID: rd_d = REV_ID;
        default: rd_d = 32'h0000_0000;
      endcase
    end
    unique case (opIn)
      CMS_OP_RESTORE: status_d = {status_q[5:4], status_q[5:2]};
      CMS_OP_READ_IDX: rdPend_d = HAS_XLATE;
      CMS_OP_PROBE: probePend_d = HAS_XLATE;
      default: ;
    endcase
    if (rdPend_q) begin
      entryHi_d = memRd.hi;
      entryLo_d = memRd.lo;
    end
    if (probePend_q) begin
      index_d = {!probeHit, 17'h0_0000, probeIdx, 8'h00};
    end
    // an exception outranks every other status update
    if (excIn.valid || addrErr_q) begin
      status_d = {status_q[3:0], 2'b00}; // push: kernel, interrupts off
      cause_d = 32'h0000_0000;
      cause_d[CMS_CAUSE_CODE_LSB +: 5] = excIn.valid ? excIn.code : CMS_CAUSE_ADDR_LOAD;
      epc_d = excIn.pc;
      if (excIn.badValid || addrErr_q) begin
        faulting_virtual_address_d = excIn.badValid ? excIn.badVaddr : xlate.paddr;
        ctx_d[CMS_CTX_BASE_LSB-1:CMS_CTX_BADVPN_LSB] = faulting_virtual_address_d[30:CMS_HI_VPN_LSB];
        entryHi_d[31:CMS_HI_VPN_LSB] = faulting_virtual_address_d[31:CMS_HI_VPN_LSB];
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      status_q <= CMS_STATUS_RST;
      cause_q <= 32'h0000_0000;
      epc_q <= 32'h0000_0000;
      faulting_virtual_address_q <= 32'h0000_0000;
      ctx_q <= 32'h0000_0000;
      entryHi_q <= 32'h0000_0000;
      entryLo_q <= 32'h0000_0000;
      index_q <= 32'h0000_0000;
      randomIdx_q <= CMS_RANDOM_RST;
      rdData_q <= 32'h0000_0000;
      copSel_q <= 4'h0;
      rdPend_q <= 1'b0;
      probePend_q <= 1'b0;
      xlate <= '{valid: 1'b0, fault: 1'b0, mapped: 1'b0, cached: 1'b0, paddr: 32'h0000_0000,
                 seg: CMS_SEG_USER};
      addrErr_q <= 1'b0;
      kernelMode_q <= 1'b0;
    end else begin
      status_q <= status_d;
      cause_q <= cause_d;
      epc_q <= epc_d;
      faulting_virtual_address_q <= faulting_virtual_address_d;
      ctx_q <= ctx_d;
      entryHi_q <= entryHi_d;
      entryLo_q <= entryLo_d;
      index_q <= index_d;
      randomIdx_q <= random_d;
      rdData_q <= rd_d;
      copSel_q <= copSel_d;
      rdPend_q <= rdPend_d;
      probePend_q <= probePend_d;
      xlate <= xlate_d;
      addrErr_q <= addrErr_d;
      kernelMode_q <= !status_d[1]; // status bit1 high means user
    end
  end
endmodule

/* rtl/cms_pkg.sv */
// package for the core mode and segment map block
package cms_pkg;
  localparam int CMS_XLATE_ENTRIES = 64;
  localparam int CMS_IDX_W = 6;
  localparam int CMS_PID_W = 6;
  localparam int CMS_NUM_COPROC = 4;
  // coprocessor register numbers for move_to/move_from_system_coproc_op
  localparam logic [4:0] CMS_REG_INDEX = 5'h00;
  localparam logic [4:0] CMS_REG_RANDOM = 5'h01;
  localparam logic [4:0] CMS_REG_ENTRY_LO = 5'h02;
  localparam logic [4:0] CMS_REG_CONTEXT = 5'h04;
  localparam logic [4:0] CMS_REG_BAD_VADDR = 5'h08;
  localparam logic [4:0] CMS_REG_ENTRY_HI = 5'h0A;
  localparam logic [4:0] CMS_REG_STATUS = 5'h0C;
  localparam logic [4:0] CMS_REG_CAUSE = 5'h0D;
  localparam logic [4:0] CMS_REG_EPC = 5'h0E;
  localparam logic [4:0] CMS_REG_REV_ID = 5'h0F;
  // field positions
  localparam int CMS_HI_PID_LSB = 6;
  localparam int CMS_HI_VPN_LSB = 12;
  localparam int CMS_LO_NC_BIT = 11;
  localparam int CMS_LO_VALID_BIT = 9;
  localparam int CMS_LO_PFN_LSB = 12;
  localparam int CMS_IDX_LSB = 8;
  localparam int CMS_IDX_PROBE_FAIL_BIT = 31;
  localparam int CMS_CTX_BADVPN_LSB = 2;
  localparam int CMS_CTX_BASE_LSB = 21;
  localparam int CMS_CAUSE_CODE_LSB = 2;
  // reset values
  // bit1 set: the core leaves reset in user mode
  localparam logic [5:0] CMS_STATUS_RST = 6'h02;
  localparam logic [5:0] CMS_RANDOM_RST = 6'h3F;
  localparam logic [5:0] CMS_RANDOM_LOW = 6'h08;
  localparam logic [31:0] CMS_REV_ID_DEFAULT = 32'h0000_5A11; // arbitrary value
  // segment boundaries
  localparam logic [2:0] CMS_SEG_KCACHED_TOP = 3'h4;
  localparam logic [2:0] CMS_SEG_KUNCACHED_TOP = 3'h5;
  localparam logic [4:0] CMS_CAUSE_ADDR_LOAD = 5'h04;
  localparam logic [4:0] CMS_CAUSE_ADDR_STORE = 5'h05;

  typedef enum logic [4:0] {
    CMS_SEG_USER = 5'b00001,
    CMS_SEG_KCACHED = 5'b00010,
    CMS_SEG_KUNCACHED = 5'b00100,
    CMS_SEG_KMAPPED = 5'b01000,
    CMS_SEG_FAULT = 5'b10000
  } cms_seg_e;

  typedef enum logic [4:0] {
    CMS_OP_NONE = 5'b00000,
    CMS_OP_READ_IDX = 5'b00001,
    CMS_OP_WRITE_IDX = 5'b00010,
    CMS_OP_WRITE_RND = 5'b00100,
    CMS_OP_PROBE = 5'b01000,
    CMS_OP_RESTORE = 5'b10000
  } cms_op_e;

  typedef struct packed {
    logic [31:0] hi;
    logic [31:0] lo;
  } cms_entry_s;

  typedef struct packed {
    logic valid;
    logic store;
    logic [31:0] vaddr;
  } cms_access_s;

  typedef struct packed {
    logic valid;
    logic fault;
    logic mapped;
    logic cached;
    logic [31:0] paddr;
    cms_seg_e seg;
  } cms_xlate_s;

  typedef struct packed {
    logic valid;
    logic [4:0] code;
    logic [31:0] pc;
    logic [31:0] badVaddr;
    logic badValid;
  } cms_except_s;
endpackage
